//--- bldcc_pkg.sv
package bldcc_pkg;
   localparam int CLK_PERIOD_NS = 4;
   localparam int FILT_TIME_NS = 1000;
   localparam int FILT_CYC = (FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SECTORS = 6;
   localparam int SYNC_STAGES = 3;
   localparam logic [2:0] CODE_ZERO = 3'h0;
   localparam logic [2:0] CODE_ONES = 3'h7;
   localparam logic [2:0] STEP_RESET = 3'h0;
   localparam logic [2:0] HALL_RESET = 3'h5;
   localparam logic [15:0] DIV12_MUL = 16'h1556;
   localparam int DIV12_SHIFT = 16;

   typedef struct packed {
      logic uh;
      logic ul;
      logic vh;
      logic vl;
      logic wh;
      logic wl;
   } bldcc_gate_s;

   typedef struct packed {
      logic [11:0] u;
      logic [11:0] v;
      logic [11:0] w;
   } bldcc_adc_s;

   localparam bldcc_gate_s GATE_OFF = '0;
endpackage

//--- bldcc_cap_mem.sv
`timescale 1ns/100ps
module bldcc_cap_mem import bldcc_pkg::*; #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 6,
   parameter int AW = 3
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [WIDTH-1:0] wdata,
   output logic [WIDTH-1:0] rdata_q
);
   // Read-before-write: the old word of the slot being replaced comes out.
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      rdata_q <= mem[addr];
      if (we) begin
         mem[addr] <= wdata;
      end
   end
endmodule

//--- bldcc_commutator.sv
// Operation
// - Step to the next conduction pattern every sixty degrees so each switch conducts for one hundred twenty.
// - Combine the three Hall levels into a code of six distinct values, one per sixty-degree sector.
// - In sensored mode, on each Hall level change, load the pattern belonging to the new code and the selected direction.
// - In sensored mode capture the free-running timer on each Hall edge and take speed from a revolution back.
// - In sensorless mode drive only two phases and watch the sign change only on the floating phase.
// - Expect six zero-crossings per electrical revolution, two per phase, giving sixty-degree resolution.
// - Compare each phase with the pseudo neutral and form a one when the phase is higher, else zero.
// - Delay the comparison pattern by thirty degrees, the delay computed from the estimated speed.
// - With converter samples, form the neutral from the sum of the three samples and compare digitally.
// - With external comparators, treat each comparator edge as an event input.
// - Filter the zero-cross inputs against commutation spikes and PWM switching noise.
// - In sensorless mode capture the timer at each commutating zero-cross and take speed from a revolution back.
// - At start-up step through the patterns at a forced rate, independent of rotor position.
`timescale 1ns/100ps
module bldcc_commutator import bldcc_pkg::*; #(
   parameter int TW = 16,
   parameter int FILT_LEN = FILT_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run_enable,
   input wire logic sensorless_mode,
   input wire logic adc_source,
   input wire logic forward_rotation_direction,
   input wire logic hall_sensor_u_input,
   input wire logic hall_sensor_v_input,
   input wire logic hall_sensor_w_input,
   input wire logic [2:0] comparator_in,
   input wire bldcc_adc_s adc_sample,
   input wire logic adc_valid,
   input wire logic [TW-1:0] startup_period,
   input wire logic [7:0] lock_count,
   output bldcc_gate_s gate_q,
   output logic fault_q,
   output logic [2:0] position_q,
   output logic [TW-1:0] speed_period_q,
   output logic speed_valid_q,
   output logic locked_q,
   output logic commutate
);
   // Fixed forward Hall order; step index i follows seq(i).
   function automatic logic [2:0] seq(input logic [2:0] s);
      case (s)
         3'h0: seq = 3'h5;
         3'h1: seq = 3'h4;
         3'h2: seq = 3'h6;
         3'h3: seq = 3'h2;
         3'h4: seq = 3'h3;
         default: seq = 3'h1;
      endcase
   endfunction

   function automatic logic [2:0] step_of(input logic [2:0] c);
      case (c)
         3'h5: step_of = 3'h0;
         3'h4: step_of = 3'h1;
         3'h6: step_of = 3'h2;
         3'h2: step_of = 3'h3;
         3'h3: step_of = 3'h4;
         default: step_of = 3'h5;
      endcase
   endfunction

   function automatic logic [2:0] step_adv(input logic [2:0] s, input logic fwd);
      if (fwd) begin
         step_adv = (s == 3'h5) ? 3'h0 : s + 3'h1;
      end else begin
         step_adv = (s == 3'h0) ? 3'h5 : s - 3'h1;
      end
   endfunction

   // Reverse rotation swaps high and low sides, which turns the torque around.
   function automatic bldcc_gate_s gate_of(input logic [2:0] c, input logic fwd);
      bldcc_gate_s g;
      g = GATE_OFF;
      case (step_of(c))
         3'h0: begin g.uh = 1'b1; g.vl = 1'b1; end
         3'h1: begin g.uh = 1'b1; g.wl = 1'b1; end
         3'h2: begin g.vh = 1'b1; g.wl = 1'b1; end
         3'h3: begin g.vh = 1'b1; g.ul = 1'b1; end
         3'h4: begin g.wh = 1'b1; g.ul = 1'b1; end
         default: begin g.wh = 1'b1; g.vl = 1'b1; end
      endcase
      if (!fwd) begin
         g = '{uh: g.ul, ul: g.uh, vh: g.vl, vl: g.vh, wh: g.wl, wl: g.wh};
      end
      gate_of = g;
   endfunction

   function automatic logic code_valid(input logic [2:0] c);
      code_valid = (c != CODE_ZERO) && (c != CODE_ONES);
   endfunction

   // Pin synchronisers; bit 2 is hall U / comparator U.
   logic [2:0] hall_s1_q, hall_s2_q, hall_s3_q, cmp_s1_q, cmp_s2_q, cmp_s3_q;
   logic [2:0] hall_q, adc_bits_q, filt_q, cmp_pat_q, pseudo_q, step_q;
   logic [$clog2(FILT_LEN+1)-1:0] filt_cnt_q;
   logic [TW-1:0] timer_q, force_cnt_q, delay_q, cap_q;
   logic [7:0] lock_cnt_q;
   logic [2:0] wptr_q;
   logic [2:0] caps_q;
   logic cap_pend_q, delay_run_q;
   logic [TW-1:0] old_cap;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hall_s1_q <= HALL_RESET;
         hall_s2_q <= HALL_RESET;
         hall_s3_q <= HALL_RESET;
         cmp_s1_q <= CODE_ZERO;
         cmp_s2_q <= CODE_ZERO;
         cmp_s3_q <= CODE_ZERO;
      end else begin
         hall_s1_q <= {hall_sensor_u_input, hall_sensor_v_input, hall_sensor_w_input};
         hall_s2_q <= hall_s1_q;
         hall_s3_q <= hall_s2_q;
         cmp_s1_q <= comparator_in;
         cmp_s2_q <= cmp_s1_q;
         cmp_s3_q <= cmp_s2_q;
      end
   end

   wire hall_stable = (hall_s2_q == hall_s3_q);
   wire hall_chg = !sensorless_mode && hall_stable && (hall_s3_q != hall_q);

   // Neutral is sum/3; comparing 3*phase with the sum avoids a divider.
   wire [13:0] adc_sum = 14'(adc_sample.u) + 14'(adc_sample.v) + 14'(adc_sample.w);
   wire [2:0] adc_cmp = {(14'(adc_sample.u) * 14'h3) > adc_sum,
                         (14'(adc_sample.v) * 14'h3) > adc_sum,
                         (14'(adc_sample.w) * 14'h3) > adc_sum};
   wire cmp_agree = (cmp_s2_q == cmp_s3_q);
   wire [2:0] zc_src = adc_source ? adc_bits_q : cmp_s3_q;
   wire src_ok = adc_source ? !(adc_valid && adc_cmp != adc_bits_q) : cmp_agree;

   // Only the phase with neither switch on may be watched.
   wire [2:0] float_mask = {!(gate_q.uh || gate_q.ul), !(gate_q.vh || gate_q.vl), !(gate_q.wh || gate_q.wl)};
   wire [2:0] cmp_next = (cmp_pat_q & ~float_mask) | (filt_q & float_mask);
   wire zc = sensorless_mode && run_enable && ((cmp_next ^ cmp_pat_q) != 3'h0);
   wire [2:0] exp_code = seq(step_adv(step_of(cmp_pat_q), forward_rotation_direction));
   wire zc_good = zc && (cmp_next == exp_code);
   wire force_tick = sensorless_mode && run_enable && !locked_q && (force_cnt_q >= startup_period);
   wire [31:0] div_prod = 32'(speed_period_q) * 32'(DIV12_MUL);
   wire [TW-1:0] delay_load = speed_valid_q ? TW'(div_prod >> DIV12_SHIFT) : TW'(1);
   wire delay_done = delay_run_q && (delay_q <= TW'(1));
   wire cap_ev = sensorless_mode ? (zc && locked_q) : hall_chg;
   wire [2:0] code_sel = !sensorless_mode ? hall_q : (locked_q ? pseudo_q : seq(step_q));
   wire code_ok = code_valid(code_sel);

   assign commutate = hall_chg || delay_done || force_tick;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hall_q <= HALL_RESET;
         adc_bits_q <= CODE_ZERO;
         filt_q <= CODE_ZERO;
         filt_cnt_q <= '0;
         cmp_pat_q <= HALL_RESET;
      end else begin
         if (hall_chg) begin
            hall_q <= hall_s3_q;
         end
         if (adc_valid) begin
            adc_bits_q <= adc_cmp;
         end
         if (!src_ok || zc_src == filt_q) begin
            filt_cnt_q <= '0;
         end else if (32'(filt_cnt_q) >= FILT_LEN - 1) begin
            filt_q <= zc_src;
            filt_cnt_q <= '0;
         end else begin
            filt_cnt_q <= filt_cnt_q + 1'b1;
         end
         if (zc) begin
            cmp_pat_q <= cmp_next;
         end else if (force_tick) begin
            cmp_pat_q <= seq(step_adv(step_q, forward_rotation_direction));
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step_q <= STEP_RESET;
         force_cnt_q <= '0;
         lock_cnt_q <= '0;
         locked_q <= 1'b0;
         delay_q <= '0;
         delay_run_q <= 1'b0;
         pseudo_q <= HALL_RESET;
      end else begin
         force_cnt_q <= (force_tick || locked_q || !sensorless_mode || !run_enable) ? '0 : force_cnt_q + 1'b1;
         if (force_tick) begin
            step_q <= step_adv(step_q, forward_rotation_direction);
         end
         if (!sensorless_mode || !run_enable) begin
            lock_cnt_q <= '0;
            locked_q <= 1'b0;
         end else if (zc && !locked_q) begin
            lock_cnt_q <= zc_good ? lock_cnt_q + 1'b1 : '0;
            locked_q <= zc_good && (lock_cnt_q + 1'b1 >= lock_count);
         end
         if (zc && locked_q) begin
            delay_q <= delay_load;
            delay_run_q <= 1'b1;
         end else if (delay_done) begin
            delay_run_q <= 1'b0;
            pseudo_q <= cmp_pat_q;
         end else if (delay_run_q) begin
            delay_q <= delay_q - 1'b1;
         end
         if (!locked_q) begin
            pseudo_q <= cmp_pat_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_q <= GATE_OFF;
         fault_q <= 1'b0;
         position_q <= CODE_ZERO;
      end else begin
         position_q <= code_sel;
         fault_q <= run_enable && !code_ok;
         gate_q <= (run_enable && code_ok) ? gate_of(code_sel, forward_rotation_direction) : GATE_OFF;
      end
   end

   bldcc_cap_mem #(.WIDTH(TW), .DEPTH(SECTORS), .AW(3)) u_cap_mem (
      .clk(clk),
      .we(cap_ev),
      .addr(wptr_q),
      .wdata(timer_q),
      .rdata_q(old_cap)
   );

   // Six captures back is one electrical revolution, so uneven sensor spacing cancels.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         timer_q <= '0;
         wptr_q <= '0;
         caps_q <= '0;
         cap_q <= '0;
         cap_pend_q <= 1'b0;
         speed_period_q <= '0;
         speed_valid_q <= 1'b0;
      end else begin
         timer_q <= timer_q + 1'b1;
         cap_pend_q <= cap_ev;
         if (cap_ev) begin
            cap_q <= timer_q;
            wptr_q <= (wptr_q == 3'(SECTORS - 1)) ? '0 : wptr_q + 1'b1;
            caps_q <= (caps_q == 3'(SECTORS)) ? caps_q : caps_q + 1'b1;
         end
         if (cap_pend_q && caps_q == 3'(SECTORS)) begin
            speed_period_q <= cap_q - old_cap;
            speed_valid_q <= 1'b1;
         end
         if (sensorless_mode && !locked_q) begin
            caps_q <= '0;
            speed_valid_q <= 1'b0;
         end
      end
   end

   a_gate_two_phase: assert property (@(posedge clk) disable iff (!rst_n)
      gate_q != GATE_OFF |-> $countones(gate_q) == 2 && (gate_q.uh + gate_q.vh + gate_q.wh) == 1)
      else $error("gate pattern does not drive exactly two phases");
   a_invalid_off: assert property (@(posedge clk) disable iff (!rst_n)
      run_enable && !code_ok |=> gate_q == GATE_OFF && fault_q)
      else $error("invalid code did not switch gates off with fault");
   a_hall_update: assert property (@(posedge clk) disable iff (!rst_n)
      hall_chg && run_enable |-> ##1 (hall_q == $past(hall_s3_q)) ##1 (!code_valid(hall_q) || gate_q != GATE_OFF))
      else $error("hall change did not load new code");
   a_float_watch: assert property (@(posedge clk) disable iff (!rst_n)
      zc |=> ((cmp_pat_q ^ $past(cmp_pat_q)) & ~$past(float_mask)) == 3'h0)
      else $error("driven phase bit changed on zero-cross");
   a_forced_step: assert property (@(posedge clk) disable iff (!rst_n)
      force_tick |=> step_q == step_adv($past(step_q), $past(forward_rotation_direction)))
      else $error("forced start-up did not advance one step");
   a_speed_calc: assert property (@(posedge clk) disable iff (!rst_n)
      cap_pend_q && caps_q == 3'(SECTORS) && !(sensorless_mode && !locked_q) |=>
      speed_period_q == $past(cap_q) - $past(old_cap))
      else $error("speed period not taken from revolution back");
   a_lock_hold: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(locked_q) |-> $past(zc_good) && $past(lock_cnt_q) + 8'h1 >= $past(lock_count))
      else $error("handover without enough consistent crossings");
   a_delay_bound: assert property (@(posedge clk) disable iff (!rst_n)
      zc && locked_q && delay_load == TW'(1) |=> delay_done)
      else $error("minimum delay did not end after one cycle");
   a_adc_compare: assert property (@(posedge clk) disable iff (!rst_n)
      adc_valid |=> adc_bits_q == $past(adc_cmp))
      else $error("converter comparison not captured");
endmodule

//--- bldcc_motor_model.sv
`timescale 1ns/100ps
module bldcc_motor_model import bldcc_pkg::*; (
   input wire logic clk,
   input wire logic [2:0] target,
   input wire logic [3:0] lag,
   output logic hall_u,
   output logic hall_v,
   output logic hall_w,
   output logic [2:0] comp
);
   // The sensors follow the commanded rotor sector after lag cycles, so slow sensors can be modelled.
   logic [2:0] pipe_q [16];
   logic [2:0] seen;

   always_ff @(posedge clk) begin
      pipe_q[0] <= target;
      for (int i = 1; i < 16; i++) begin
         pipe_q[i] <= pipe_q[i-1];
      end
   end

   // Three sensors spaced a third of a turn apart give the sector code {u,v,w}.
   assign seen = (lag == 4'h0) ? target : pipe_q[lag - 4'h1];
   assign {hall_u, hall_v, hall_w} = seen;
   // A rotor at standstill gives no back-EMF, so the comparators hold a fixed pattern.
   assign comp = 3'h5;
endmodule

//--- tb_bldc_six_step_commutator.sv
`timescale 1ns/100ps
module tb_bldc_six_step_commutator import bldcc_pkg::*;;
   typedef struct packed {logic dir; logic [2:0] code; logic [5:0] gate;} bldcc_row_s;
   logic clk, rst_n, run_enable, sensorless_mode, dir, hu, hv, hw, fault_q, speed_valid_q, locked_q, commutate;
   logic [2:0] target, comp, position_q;
   logic [3:0] lag;
   logic [15:0] startup_period, speed_period_q;
   logic [7:0] lock_count;
   logic adc_src, adc_vld;
   bldcc_gate_s gate_q;
   bldcc_adc_s adc_smp;
   int errors = 0;
   int n_compared = 0;
   int n;
   logic [2:0] fwd [6] = '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5};
   bldcc_row_s rows [12] = '{'{1'b1, 3'h4, 6'h21}, '{1'b1, 3'h6, 6'h09}, '{1'b1, 3'h2, 6'h18},
      '{1'b1, 3'h3, 6'h12}, '{1'b1, 3'h1, 6'h06}, '{1'b1, 3'h5, 6'h24}, '{1'b0, 3'h1, 6'h09},
      '{1'b0, 3'h3, 6'h21}, '{1'b0, 3'h2, 6'h24}, '{1'b0, 3'h6, 6'h06}, '{1'b0, 3'h4, 6'h12},
      '{1'b0, 3'h5, 6'h18}};

   bldcc_commutator #(.TW(16), .FILT_LEN(4)) i_bldcc_commutator (.clk(clk), .rst_n(rst_n),
      .run_enable(run_enable), .sensorless_mode(sensorless_mode), .adc_source(adc_src),
      .forward_rotation_direction(dir), .hall_sensor_u_input(hu), .hall_sensor_v_input(hv),
      .hall_sensor_w_input(hw), .comparator_in(comp), .adc_sample(adc_smp), .adc_valid(adc_vld),
      .startup_period(startup_period), .lock_count(lock_count), .gate_q(gate_q), .fault_q(fault_q),
      .position_q(position_q), .speed_period_q(speed_period_q), .speed_valid_q(speed_valid_q),
      .locked_q(locked_q), .commutate(commutate));
   bldcc_motor_model i_bldcc_motor_model (.clk(clk), .target(target), .lag(lag), .hall_u(hu),
      .hall_v(hv), .hall_w(hw), .comp(comp));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wait_comm(output int c);
      c = 0;
      do begin
         @(posedge clk);
         #1;
         c++;
      end while (commutate !== 1'b1 && c < 200);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(4 * 20000);
      errors++;
      finish_test();
   end

   initial begin
      rst_n = 1'b0;
      run_enable = 1'b1;
      sensorless_mode = 1'b0;
      dir = 1'b1;
      target = HALL_RESET;
      lag = 4'h0;
      startup_period = 16'h0013;
      lock_count = 8'hff;
      adc_src = 1'b0;
      adc_vld = 1'b0;
      adc_smp = '0;
      repeat (3) @(posedge clk);
      #1;
      chk("reset gate", 16'h0000, 16'(gate_q));
      chk("reset speed valid", 16'h0000, 16'(speed_valid_q));
      @(posedge clk) rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("gate after reset", 16'h0024, 16'(gate_q));
      $display("test reset done");
      // Each row steps one sector; a missing commutate pulse or wrong gate pattern is caught.
      foreach (rows[k]) begin
         @(posedge clk);
         dir <= rows[k].dir;
         target <= rows[k].code;
         wait_comm(n);
         chk("commutate", 16'h0001, 16'(commutate));
         // The code is latched on the edge after detection and the gates follow one edge later.
         repeat (2) @(posedge clk);
         #1;
         chk("gate", 16'(rows[k].gate), 16'(gate_q));
         chk("position", 16'(rows[k].code), 16'(position_q));
         chk("two phases", 16'h0002, 16'($countones(gate_q)));
      end
      $display("test table done");
      // Slow sensors, steps every 40 cycles; one revolution is six steps.
      @(posedge clk) dir <= 1'b1;
      lag <= 4'h3;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk) target <= fwd[k % 6];
         repeat (39) @(posedge clk);
      end
      #1;
      chk("speed valid", 16'h0001, 16'(speed_valid_q));
      chk("speed period", 16'h00f0, speed_period_q);
      $display("test speed done");
      for (int k = 0; k < 2; k++) begin
         @(posedge clk) target <= (k == 0) ? CODE_ZERO : CODE_ONES;
         repeat (8) @(posedge clk);
         #1;
         chk("fault", 16'h0001, 16'(fault_q));
         chk("gate off", 16'h0000, 16'(gate_q));
      end
      @(posedge clk) target <= 3'h5;
      repeat (8) @(posedge clk);
      #1;
      chk("fault cleared", 16'h0000, 16'(fault_q));
      chk("gate restored", 16'h0024, 16'(gate_q));
      $display("test invalid codes done");
      @(posedge clk) run_enable <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("disabled gate", 16'h0000, 16'(gate_q));
      @(posedge clk) run_enable <= 1'b1;
      sensorless_mode <= 1'b1;
      lag <= 4'h0;
      // Standstill: only the forced rate may step the pattern.
      wait_comm(n);
      wait_comm(n);
      wait_comm(n);
      chk("forced interval", 16'h0014, 16'(n));
      chk("unlocked", 16'h0000, 16'(locked_q));
      @(posedge clk);
      #1;
      chk("sensorless two phases", 16'h0002, 16'($countones(gate_q)));
      $display("test startup done");
      // The neutral is a third of the sum, so only the U sample sits above it.
      @(posedge clk) adc_src <= 1'b1;
      adc_vld <= 1'b1;
      adc_smp <= {12'h300, 12'h100, 12'h100};
      @(posedge clk) adc_vld <= 1'b0;
      #1;
      chk("adc compare", 16'h0004, 16'(i_bldcc_commutator.adc_bits_q));
      repeat (6) @(posedge clk);
      #1;
      chk("adc filtered", 16'h0004, 16'(i_bldcc_commutator.filt_q));
      // A single V-high sample must not get through the filter.
      @(posedge clk) adc_vld <= 1'b1;
      adc_smp <= {12'h100, 12'h300, 12'h100};
      @(posedge clk) adc_smp <= {12'h300, 12'h100, 12'h100};
      @(posedge clk) adc_vld <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      chk("adc glitch held", 16'h0004, 16'(i_bldcc_commutator.filt_q));
      $display("test converter done");
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("mid reset gate", 16'h0000, 16'(gate_q));
      chk("mid reset position", 16'h0000, 16'(position_q));
      chk("mid reset fault", 16'h0000, 16'(fault_q));
      $display("test mid reset done");
      finish_test();
   end
endmodule
